// File: shared/sample_clamp_defs.svh
/*
  constants for the sample and clamp control block: register offsets, field positions,
  reset values and codes. assumes inclusion by bare name from design files.
*/
`ifndef SAMPLE_CLAMP_DEFS_SVH
`define SAMPLE_CLAMP_DEFS_SVH

// ********************************************************************
// register map
// ********************************************************************
`define CONTROL_ADDR 8'h00
`define STATUS_ADDR 8'h04
`define CONTROL_RESET 16'h0110

// ********************************************************************
// control field positions
// ********************************************************************
`define F_MODE_LO 0
`define F_MODE_HI 1
`define F_MONO_LO 2
`define F_MONO_HI 3
`define F_CLAMP_EN 4
`define F_QUAL_SEL 5
`define F_COMPAT 6
`define F_AUTO_CYC 7
`define F_DOUBLE_SMP 8
`define F_RS_POS_LO 9
`define F_RS_POS_HI 10
`define F_COEF_LO 11
`define F_COEF_HI 12

// ********************************************************************
// codes
// ********************************************************************
`define MODE_PIXEL 2'h0
`define MODE_TWO_CHAN 2'h1
`define MODE_MONO 2'h2
`define MODE_LINE_SEQ 2'h3
`define COLOUR_RED 2'h0
`define COLOUR_GREEN 2'h1
`define COLOUR_BLUE 2'h2
`define POWER_ALL 3'h7
`define POWER_TWO 3'h3
`define POWER_RED 3'h1

`endif

// File: shared/sample_clamp_pkg.sv
/*
  types shared by the sample and clamp control block.
  assumes nothing of its surroundings.
*/
package sample_clamp_pkg;

  typedef enum logic [1:0] {
    PIXEL_COLOUR,
    TWO_CHANNEL,
    MONOCHROME,
    LINE_SEQUENTIAL
  } sample_mode_t;

  typedef enum logic [1:0] {
    CT_IDLE,
    CT_WAIT_RISE,
    CT_COUNT,
    CT_WINDOW
  } compat_state_t;

endpackage

// File: hw/ccd_sample_clamp_control.sv
/*
  sampling mode, channel power, coefficient select, reset level clamp and sample
  instant logic of a three channel sensor front end.
  assumes the strobe pins and the master clock pin are asynchronous to clk, and a
  plain register port whose read data is taken in the cycle after the read strobe.
*/
// Added by the designer: the strobed register port and the register offsets.
`include "sample_clamp_defs.svh"

module ccd_sample_clamp_control #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rd_data,
  input wire logic master_clock,
  input wire logic reset_sample_strobe,
  input wire logic video_sample_strobe,
  output logic [2:0] reset_level_clamp,
  output logic clamp_gate,
  output logic video_sample,
  output logic reset_sample,
  output logic bias_sample,
  output logic [2:0] convert_request,
  output logic [2:0] channel_power,
  output logic [1:0] coef_select
);

  // ********************************************************************
  // pin synchronisers
  // ********************************************************************
  localparam int PIN_MCLK = 0;
  localparam int PIN_RS = 1;
  localparam int PIN_VS = 2;
  logic [2:0] pin_s1, pin_s2, pin_s3, pin_f, pin_rise, pin_fall;
  // a change counts only once stages two and three agree, filtering one-cycle glitches
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_s3 <= 3'h0;
    end else begin
      pin_s1 <= {video_sample_strobe, reset_sample_strobe, master_clock};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_filter
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          pin_f[gi] <= 1'b0;
        end else if (pin_s2[gi] == pin_s3[gi]) begin
          pin_f[gi] <= pin_s3[gi];
        end
      end
      assign pin_rise[gi] = (pin_s2[gi] == pin_s3[gi]) && pin_s3[gi] && !pin_f[gi];
      assign pin_fall[gi] = (pin_s2[gi] == pin_s3[gi]) && !pin_s3[gi] && pin_f[gi];
    end
  endgenerate
  logic rs_level, vs_level, mclk_rise, mclk_edge;
  assign rs_level = pin_f[PIN_RS];
  assign vs_level = pin_f[PIN_VS];
  assign mclk_rise = pin_rise[PIN_MCLK];
  assign mclk_edge = pin_rise[PIN_MCLK] | pin_fall[PIN_MCLK];

  // ********************************************************************
  // registers
  // ********************************************************************
  logic [DATA_W-1:0] control, next_rd_data;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      control <= `CONTROL_RESET;
    end else if (wr_en && addr == `CONTROL_ADDR) begin
      control <= wr_data;
    end
  end

  logic clamp_enable, clamp_qualify_select, compat_timing_mode, auto_cycle_enable;
  logic double_sampling_enable;
  logic [1:0] reset_sample_position, mono_select, manual_coef;
  sample_clamp_pkg::sample_mode_t mode;
  assign clamp_enable = control[`F_CLAMP_EN];
  assign clamp_qualify_select = control[`F_QUAL_SEL];
  assign compat_timing_mode = control[`F_COMPAT];
  assign auto_cycle_enable = control[`F_AUTO_CYC];
  assign double_sampling_enable = control[`F_DOUBLE_SMP];
  assign reset_sample_position = control[`F_RS_POS_HI:`F_RS_POS_LO];
  assign mono_select = control[`F_MONO_HI:`F_MONO_LO];
  assign manual_coef = control[`F_COEF_HI:`F_COEF_LO];

  always_comb begin
    case (control[`F_MODE_HI:`F_MODE_LO])
      `MODE_PIXEL: mode = sample_clamp_pkg::PIXEL_COLOUR;
      `MODE_TWO_CHAN: mode = sample_clamp_pkg::TWO_CHANNEL;
      `MODE_MONO: mode = sample_clamp_pkg::MONOCHROME;
      default: mode = sample_clamp_pkg::LINE_SEQUENTIAL;
    endcase
  end

  logic line_seq, auto_cycling;
  assign line_seq = (mode == sample_clamp_pkg::LINE_SEQUENTIAL);
  assign auto_cycling = line_seq && auto_cycle_enable;

  always_comb begin
    next_rd_data = '0;
    if (rd_en) begin
      case (addr)
        `CONTROL_ADDR: next_rd_data = control;
        `STATUS_ADDR: next_rd_data = {{(DATA_W-6){1'b0}}, reset_level_clamp[0],
                                      channel_power, coef_select};
        default: next_rd_data = '0;
      endcase
    end
  end

  // read data stands for exactly one cycle, zero otherwise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // ********************************************************************
  // channel power
  // ********************************************************************
  logic [2:0] next_power;

  always_comb begin
    case (mode)
      sample_clamp_pkg::PIXEL_COLOUR: next_power = `POWER_ALL;
      sample_clamp_pkg::TWO_CHANNEL: next_power = `POWER_TWO;
      sample_clamp_pkg::MONOCHROME: begin
        // an unused select code falls back to red
        case (mono_select)
          `COLOUR_GREEN: next_power = 3'h2;
          `COLOUR_BLUE: next_power = 3'h4;
          default: next_power = `POWER_RED;
        endcase
      end
      default: next_power = `POWER_RED;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      channel_power <= `POWER_ALL;
    end else begin
      channel_power <= next_power;
    end
  end

  // ********************************************************************
  // coefficient select
  // ********************************************************************
  logic line_seq_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line_seq_q <= 1'b0;
    end else begin
      line_seq_q <= line_seq;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      coef_select <= `COLOUR_RED;
    end else if (!line_seq) begin
      coef_select <= `COLOUR_RED;
    end else if (!line_seq_q) begin
      coef_select <= `COLOUR_RED;
    end else if (!auto_cycle_enable) begin
      coef_select <= manual_coef;
    end else if (pin_rise[PIN_RS]) begin
      case (coef_select)
        `COLOUR_RED: coef_select <= `COLOUR_GREEN;
        `COLOUR_GREEN: coef_select <= `COLOUR_BLUE;
        default: coef_select <= `COLOUR_RED;
      endcase
    end
  end

  // ********************************************************************
  // compat timing generator
  // ********************************************************************
  sample_clamp_pkg::compat_state_t state;
  logic [2:0] edge_cnt;
  logic qualified, rs_window;
  assign rs_window = (state == sample_clamp_pkg::CT_WINDOW);

  // reset sample window opens at master clock edge position+1 after the video sample
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= sample_clamp_pkg::CT_IDLE;
      edge_cnt <= 3'h0;
    end else if (!compat_timing_mode) begin
      state <= sample_clamp_pkg::CT_IDLE;
      edge_cnt <= 3'h0;
    end else if (pin_fall[PIN_VS]) begin
      state <= sample_clamp_pkg::CT_WAIT_RISE;
      edge_cnt <= 3'h0;
    end else begin
      case (state)
        sample_clamp_pkg::CT_WAIT_RISE: begin
          if (mclk_rise) begin
            state <= double_sampling_enable ? sample_clamp_pkg::CT_COUNT
                                            : sample_clamp_pkg::CT_IDLE;
          end
        end
        sample_clamp_pkg::CT_COUNT: begin
          if (mclk_edge) begin
            edge_cnt <= edge_cnt + 3'h1;
            if (edge_cnt == {1'b0, reset_sample_position}) begin
              state <= sample_clamp_pkg::CT_WINDOW;
            end
          end
        end
        sample_clamp_pkg::CT_WINDOW: begin
          if (mclk_edge) begin
            state <= sample_clamp_pkg::CT_IDLE;
          end
        end
        default: state <= sample_clamp_pkg::CT_IDLE;
      endcase
    end
  end

  // reset strobe level caught at the master clock rise while video strobe is high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      qualified <= 1'b0;
    end else if (mclk_rise && vs_level) begin
      qualified <= rs_level;
    end
  end

  // ********************************************************************
  // clamp control
  // ********************************************************************
  logic next_gate, next_clamp;
  always_comb begin
    if (!double_sampling_enable) begin
      next_gate = 1'b0;
    end else if (auto_cycling) begin
      next_gate = rs_window && clamp_qualify_select;
    end else begin
      next_gate = rs_window && qualified;
    end
  end

  always_comb begin
    if (!clamp_enable) begin
      next_clamp = 1'b0;
    end else if (compat_timing_mode) begin
      next_clamp = next_gate;
    end else if (clamp_qualify_select) begin
      next_clamp = rs_level && vs_level;
    end else begin
      next_clamp = rs_level;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reset_level_clamp <= 3'h0;
      clamp_gate <= 1'b0;
    end else begin
      reset_level_clamp <= {3{next_clamp}};
      clamp_gate <= compat_timing_mode && clamp_enable && next_gate;
    end
  end

  // ********************************************************************
  // sample instants
  // ********************************************************************
  logic next_video, next_reset;
  always_comb begin
    if (compat_timing_mode) begin
      next_video = (state == sample_clamp_pkg::CT_WAIT_RISE) && mclk_rise &&
                   !pin_fall[PIN_VS];
      next_reset = double_sampling_enable && rs_window && mclk_edge &&
                   !pin_fall[PIN_VS];
    end else begin
      next_video = pin_fall[PIN_VS];
      next_reset = double_sampling_enable && pin_fall[PIN_RS];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      video_sample <= 1'b0;
      reset_sample <= 1'b0;
      bias_sample <= 1'b0;
      convert_request <= 3'h0;
    end else begin
      video_sample <= next_video;
      reset_sample <= next_reset;
      bias_sample <= next_video && !double_sampling_enable;
      convert_request <= next_video ? next_power : 3'h0;
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_enable_off;
    (!clamp_enable)[*2] |-> reset_level_clamp == 3'h0;
  endproperty
  a_enable_off: assert property (p_enable_off) else $error("clamp closed while disabled");
  property p_common_clamp;
    reset_level_clamp == 3'h0 || reset_level_clamp == 3'h7;
  endproperty
  a_common_clamp: assert property (p_common_clamp) else $error("clamp switches differ");
  property p_direct;
    clamp_enable && !compat_timing_mode && !clamp_qualify_select
      |=> reset_level_clamp[0] == $past(rs_level);
  endproperty
  a_direct: assert property (p_direct) else $error("clamp not following reset strobe");
  property p_qualified;
    clamp_enable && !compat_timing_mode && clamp_qualify_select && !vs_level
      |=> reset_level_clamp == 3'h0;
  endproperty
  a_qualified: assert property (p_qualified) else $error("clamp closed without video");
  property p_compat_needs_ds;
    (compat_timing_mode && !double_sampling_enable)[*2] |-> !reset_level_clamp[0] && !clamp_gate;
  endproperty
  a_compat_needs_ds: assert property (p_compat_needs_ds) else $error("compat clamp no ds");
  property p_video_fall;
    !compat_timing_mode && pin_fall[PIN_VS] |=> video_sample ##1 !video_sample;
  endproperty
  a_video_fall: assert property (p_video_fall) else $error("video sample missed");
  property p_bias;
    video_sample |-> bias_sample == !$past(double_sampling_enable);
  endproperty
  a_bias: assert property (p_bias) else $error("bias sample mismatch");
  property p_compat_video;
    compat_timing_mode && state == sample_clamp_pkg::CT_WAIT_RISE && mclk_rise &&
      !pin_fall[PIN_VS] |=> video_sample;
  endproperty
  a_compat_video: assert property (p_compat_video) else $error("compat video missed");
  property p_auto_cycle;
    line_seq && line_seq_q && auto_cycle_enable && pin_rise[PIN_RS] &&
      coef_select == `COLOUR_RED |=> coef_select == `COLOUR_GREEN;
  endproperty
  a_auto_cycle: assert property (p_auto_cycle) else $error("auto cycle step wrong");
  property p_line_seq_power;
    line_seq ##1 line_seq |-> channel_power == `POWER_RED;
  endproperty
  a_line_seq_power: assert property (p_line_seq_power) else $error("line seq power");
  property p_two_power;
    mode == sample_clamp_pkg::TWO_CHANNEL |=> !channel_power[2] ||
      mode != sample_clamp_pkg::TWO_CHANNEL;
  endproperty
  a_two_power: assert property (p_two_power) else $error("blue powered in two channel");
  property p_line_entry;
    line_seq && !line_seq_q |=> coef_select == `COLOUR_RED;
  endproperty
  a_line_entry: assert property (p_line_entry) else $error("coef not red on entry");

endmodule

// File: tb/scan_timing_model.sv
/*
  scanner timing controller model: free running master clock and the two sample strobes.
  assumes the bench calls its tasks from one process at a time.
*/
module scan_timing_model (
  input wire logic clk,
  output logic master_clock,
  output logic reset_sample_strobe,
  output logic video_sample_strobe
);
  timeunit 1ns;
  timeprecision 100ps;

  // ********************************************************************
  // master clock
  // ********************************************************************
  // each half spans about five system clocks, so the pin filter always sees it
  initial begin
    master_clock = 1'b0;
    reset_sample_strobe = 1'b0;
    video_sample_strobe = 1'b0;
    #1.7;
    forever #41.3 master_clock = ~master_clock;
  end

  // ********************************************************************
  // strobe sequences
  // ********************************************************************
  task automatic set_pins(input logic rs, input logic vs);
    @(posedge clk);
    reset_sample_strobe <= rs;
    video_sample_strobe <= vs;
  endtask

  task automatic pixel(input logic rs_on);
    @(posedge master_clock);
    #3 video_sample_strobe = 1'b1;
    @(negedge master_clock);
    #5 video_sample_strobe = 1'b0;
    @(negedge master_clock);
    #1 reset_sample_strobe = rs_on;
    @(negedge master_clock);
    reset_sample_strobe = 1'b0;
    repeat (2) @(posedge master_clock);
  endtask

  // video high across one master clock rise, reset strobe as the clamp qualifier
  task automatic compat_pixel(input logic rs_on);
    @(negedge master_clock);
    #2 video_sample_strobe = 1'b1;
    reset_sample_strobe = rs_on;
    @(negedge master_clock);
    #2 video_sample_strobe = 1'b0;
    reset_sample_strobe = 1'b0;
    repeat (6) @(posedge master_clock);
  endtask
endmodule

// File: tb/tb_top.sv
/*
  self-checking bench for the sample and clamp control block.
  assumes the register map header and the scanner timing model beside it.
*/
`include "sample_clamp_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {string what; logic [15:0] val; logic [15:0] mask;} note_t;
  logic clk, rst_n, wr_en, rd_en, rd_d, gate_seen, ds_exp, en, qs;
  logic [7:0] addr;
  logic [15:0] wr_data, rd_data;
  logic master_clock, reset_sample_strobe, video_sample_strobe;
  logic [2:0] reset_level_clamp, convert_request, channel_power, pw_exp;
  logic clamp_gate, video_sample, reset_sample, bias_sample;
  logic [1:0] coef_select;
  logic [31:0] seed;
  note_t notes[$];
  note_t cur;
  int failures, cmp_count, vcnt, rcnt;
  logic [3:0] mcode [7] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'ha, 4'he, 4'h3};
  logic [2:0] pw_tab [7] = '{3'h7, 3'h3, 3'h1, 3'h2, 3'h4, 3'h1, 3'h1};
  // en, double sampling, qualifier, position, gate expected
  logic [5:0] ctab [7] = '{6'b111001, 6'b111011, 6'b111101, 6'b111111,
                           6'b110000, 6'b101000, 6'b011000};

  ccd_sample_clamp_control u_ccd_sample_clamp_control (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .master_clock(master_clock),
    .reset_sample_strobe(reset_sample_strobe), .video_sample_strobe(video_sample_strobe),
    .reset_level_clamp(reset_level_clamp), .clamp_gate(clamp_gate),
    .video_sample(video_sample), .reset_sample(reset_sample), .bias_sample(bias_sample),
    .convert_request(convert_request), .channel_power(channel_power),
    .coef_select(coef_select)
  );

  scan_timing_model u_scan_timing_model (
    .clk(clk), .master_clock(master_clock),
    .reset_sample_strobe(reset_sample_strobe), .video_sample_strobe(video_sample_strobe)
  );

  // ********************************************************************
  // helpers
  // ********************************************************************
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] v, input logic [15:0] m,
                    input string what);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    notes.push_back('{what, v, m});
    @(posedge clk);
    rd_en <= 1'b0;
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ********************************************************************
  // clock, watchdog, monitor
  // ********************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // whole run is well under 10k cycles
  initial begin
    #200us;
    failures++;
    final_report();
  end

  // read data is only valid the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d === 1'b1) begin
      cur = notes.pop_front();
      check(cur.what, rd_data & cur.mask, cur.val & cur.mask);
    end
    if (video_sample === 1'b1) begin
      vcnt++;
      check("convert", {13'h0, convert_request}, {13'h0, pw_exp});
      check("bias", {15'h0, bias_sample}, {15'h0, !ds_exp});
    end
    if (reset_sample === 1'b1) begin
      rcnt++;
    end
    if (clamp_gate === 1'b1) begin
      gate_seen = 1'b1;
      check("gate clamp", {13'h0, reset_level_clamp}, 16'h0007);
    end
    rd_d <= rd_en;
  end

  // ********************************************************************
  // scenarios
  // ********************************************************************
  initial begin
    rst_n = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 16'h0000;
    seed = 32'hae556569;
    ds_exp = 1'b1;
    pw_exp = 3'h7;
    gate_seen = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(`CONTROL_ADDR, `CONTROL_RESET, 16'hffff, "control");
    rd(`STATUS_ADDR, 16'h001c, 16'hffff, "status");
    wr(`STATUS_ADDR, 16'hffff);
    rd(8'h08, 16'h0000, 16'hffff, "unmapped");
    rd(`STATUS_ADDR, 16'h001c, 16'hffff, "status ro");
    // every mode and mono select, one pixel each
    for (int i = 0; i < 7; i++) begin
      pw_exp = pw_tab[i];
      wr(`CONTROL_ADDR, {12'h011, mcode[i]});
      rd(`STATUS_ADDR, {11'h0, pw_tab[i], 2'h0}, 16'h001c, "power");
      u_scan_timing_model.pixel(1'b0);
    end
    pw_exp = 3'h7;
    for (int d = 0; d < 2; d++) begin
      ds_exp = d[0];
      wr(`CONTROL_ADDR, {7'h0, d[0], 8'h10});
      vcnt = 0;
      rcnt = 0;
      u_scan_timing_model.pixel(1'b1);
      repeat (8) @(posedge clk);
      check("video count", vcnt[15:0], 16'h0001);
      check("reset count", rcnt[15:0], {15'h0, d[0]});
    end
    // random strobe levels against enable and qualify settings
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      en = seed[2];
      qs = seed[3];
      ds_exp = !qs;
      wr(`CONTROL_ADDR, {7'h0, !qs, 2'h0, qs, en, 4'h0});
      u_scan_timing_model.set_pins(seed[4], seed[9]);
      repeat (8) @(posedge clk);
      rd(`STATUS_ADDR, {10'h0, en & (qs ? seed[4] & seed[9] : seed[4]), 5'h0}, 16'h0020,
         "clamp");
    end
    u_scan_timing_model.set_pins(1'b0, 1'b0);
    // let a last video fall land while the old mode and sampling setting still stand
    repeat (8) @(posedge clk);
    ds_exp = 1'b1;
    wr(`CONTROL_ADDR, 16'h0193);
    for (int i = 1; i < 5; i++) begin
      u_scan_timing_model.set_pins(1'b1, 1'b0);
      repeat (6) @(posedge clk);
      u_scan_timing_model.set_pins(1'b0, 1'b0);
      repeat (6) @(posedge clk);
      rd(`STATUS_ADDR, {14'h0, 2'(i % 3)}, 16'h0003, "coef step");
    end
    wr(`CONTROL_ADDR, 16'h0190);
    wr(`CONTROL_ADDR, 16'h0193);
    rd(`STATUS_ADDR, 16'h0000, 16'h0003, "coef entry");
    wr(`CONTROL_ADDR, 16'h1113);
    rd(`STATUS_ADDR, 16'h0002, 16'h0003, "coef manual");
    // compatibility timing, each reset sample position and each refusal
    for (int i = 0; i < 7; i++) begin
      ds_exp = ctab[i][4];
      wr(`CONTROL_ADDR, {5'h0, ctab[i][2:1], ctab[i][4], 3'h2, ctab[i][5], 4'h0});
      repeat (4) @(posedge clk);
      gate_seen = 1'b0;
      vcnt = 0;
      rcnt = 0;
      u_scan_timing_model.compat_pixel(ctab[i][3]);
      check("compat video", vcnt[15:0], 16'h0001);
      check("compat gate", {15'h0, gate_seen}, {15'h0, ctab[i][0]});
      check("compat reset", rcnt[15:0], {15'h0, ctab[i][4]});
    end
    // compat with line sequential auto cycling: qualify alone decides, reset strobe held low
    pw_exp = 3'h1;
    ds_exp = 1'b1;
    for (int q = 0; q < 2; q++) begin
      wr(`CONTROL_ADDR, q[0] ? 16'h01f3 : 16'h01d3);
      repeat (4) @(posedge clk);
      gate_seen = 1'b0;
      vcnt = 0;
      u_scan_timing_model.compat_pixel(1'b0);
      check("auto video", vcnt[15:0], 16'h0001);
      check("auto gate", {15'h0, gate_seen}, {15'h0, q[0]});
    end
    final_report();
  end
endmodule
